/* File: rtl/dual_image_boot_selector.sv */
/*
 * dual-image boot selector: picks an image from the jumper, copies it from
 * configuration flash into configuration ram, falls back on crc error or
 * watchdog expiry, records the cause.
 * assumes flash answers reads one cycle after the address.
 */
// Summary of operation
// - jumper open image 0, closed image 1
// - two images in flash, load one
// - copy selected image into configuration ram
// - sample jumper after power-up
// - upgrade register image overrides jumper later
// - on failure configure from other image
// - crc error or watchdog expiry trigger fallback
// - user reads cause and failed image
// - second error halts until reconfig request
// - auto-reconfig restarts after second error
// - status, config or upgrade request restarts
`timescale 1ns/1ps
module dual_image_boot_selector
    import boot_sel_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // board pins
    input wire logic image_jumper_in,
    input wire logic config_status_line_n_in,
    input wire logic config_request_n_in,
    // user upgrade logic
    input wire logic upgrade_reconfig_request_n_in,
    input wire logic upgrade_image_valid_in,
    input wire logic upgrade_image_in,
    input wire logic auto_reconfig_en_in,
    input wire logic user_wdog_kick_in,
    // configuration flash read port
    output logic [FLASH_ADDR_W:0] flash_addr_out,
    output logic flash_rd_out,
    input wire logic [DATA_W-1:0] flash_data_in,
    input wire logic [15:0] image_crc_in,
    // configuration ram write port
    output logic [FLASH_ADDR_W-1:0] configuration_ram_addr_out,
    output logic [DATA_W-1:0] configuration_ram_data_out,
    output logic configuration_ram_we_out,
    // status
    output logic user_mode_out,
    output logic active_image_out,
    output logic failed_image_out,
    output logic [1:0] error_cause_out,
    output logic halted_out
);
    import boot_sel_pkg::*;

    logic jumper_s, status_n_s, config_n_s;
    boot_state_e state_r, state_nxt;
    logic [FLASH_ADDR_W-1:0] cnt_r, cnt_nxt;
    logic [15:0] crc_r, crc_nxt;
    logic image_r, image_nxt, fallback_r, fallback_nxt, failed_r, failed_nxt;
    logic [1:0] cause_r, cause_nxt;
    logic ovr_valid_r, ovr_valid_nxt, ovr_img_r, ovr_img_nxt;
    logic [16:0] wdog_r, wdog_nxt;
    logic rd_r, rd_nxt, we_r, we_nxt, rd2_r, rd2_nxt;
    logic [FLASH_ADDR_W-1:0] raddr2_r, raddr2_nxt;
    logic user_r, halt_r;
    logic [FLASH_ADDR_W-1:0] waddr_r, waddr_nxt;
    logic [DATA_W-1:0] wdata_r, wdata_nxt;
    logic reconfig_req;

    // pins cross into the clock domain
    sync2 u_sync_jumper (.clk_in(clk_in), .reset_n_in(reset_n_in), .d_in(image_jumper_in),
        .rst_val_in(1'b1), .q_out(jumper_s));
    sync2 u_sync_status (.clk_in(clk_in), .reset_n_in(reset_n_in), .d_in(config_status_line_n_in),
        .rst_val_in(1'b1), .q_out(status_n_s));
    sync2 u_sync_config (.clk_in(clk_in), .reset_n_in(reset_n_in), .d_in(config_request_n_in),
        .rst_val_in(1'b1), .q_out(config_n_s));

    // crc step over one flash word
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [DATA_W-1:0] d);
        logic [15:0] r;
        r = c;
        for (int i = DATA_W - 1; i >= 0; i--)
        begin
            r = (r[15] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction : crc_step

    // any of the reconfiguration sources
    assign reconfig_req = !status_n_s || !config_n_s || !upgrade_reconfig_request_n_in;

    // next-state logic
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        crc_nxt = crc_r;
        image_nxt = image_r;
        fallback_nxt = fallback_r;
        failed_nxt = failed_r;
        cause_nxt = cause_r;
        ovr_valid_nxt = ovr_valid_r;
        ovr_img_nxt = ovr_img_r;
        wdog_nxt = wdog_r;
        rd_nxt = 1'b0;
        we_nxt = 1'b0;
        rd2_nxt = rd_r; // flash answers one cycle after the read edge
        raddr2_nxt = faddr_r[FLASH_ADDR_W-1:0];
        waddr_nxt = waddr_r;
        wdata_nxt = wdata_r;
        if (upgrade_image_valid_in)
        begin
            ovr_valid_nxt = 1'b1;
            ovr_img_nxt = upgrade_image_in;
        end
        case (state_r)
            ST_SAMPLE:
            begin
                // wait for the pin synchronisers to settle before sampling
                if (cnt_r != SAMPLE_WAIT)
                    cnt_nxt = cnt_r + 12'h0_001;
                else
                begin
                    // open jumper reads high through the pull-up: image 0
                    image_nxt = ovr_valid_r ? ovr_img_r : !jumper_s;
                    cnt_nxt = ADDR_ZERO;
                    crc_nxt = CRC_INIT;
                    state_nxt = ST_LOAD;
                end
            end
            ST_LOAD:
            begin
                // flash word for cnt is read; word from two counts back written to ram
                rd_nxt = (cnt_r != IMAGE_WORDS);
                if (rd2_r)
                begin
                    we_nxt = 1'b1;
                    waddr_nxt = raddr2_r;
                    wdata_nxt = flash_data_in;
                    crc_nxt = crc_step(crc_r, flash_data_in);
                end
                if (cnt_r != IMAGE_WORDS)
                    cnt_nxt = cnt_r + 12'h0_001;
                else if (!rd_r && !rd2_r)
                    state_nxt = ST_CHECK;
            end
            ST_CHECK:
            begin
                wdog_nxt = 17'(WDOG_CYCLES);
                if (crc_r == image_crc_in)
                    state_nxt = ST_USER;
                else
                begin
                    cause_nxt = CAUSE_CRC;
                    failed_nxt = image_r;
                    if (fallback_r)
                        state_nxt = ST_HALT;
                    else
                    begin
                        fallback_nxt = 1'b1;
                        image_nxt = !image_r;
                        cnt_nxt = ADDR_ZERO;
                        crc_nxt = CRC_INIT;
                        state_nxt = ST_LOAD;
                    end
                end
            end
            ST_USER:
            begin
                wdog_nxt = user_wdog_kick_in ? 17'(WDOG_CYCLES) : wdog_r - 17'h0_0001;
                if (reconfig_req)
                begin
                    fallback_nxt = 1'b0;
                    cnt_nxt = ADDR_ZERO;
                    state_nxt = ST_SAMPLE;
                end
                else if (wdog_r == 17'h0_0000)
                begin
                    cause_nxt = CAUSE_WDOG;
                    failed_nxt = image_r;
                    if (fallback_r)
                        state_nxt = ST_HALT;
                    else
                    begin
                        fallback_nxt = 1'b1;
                        image_nxt = !image_r;
                        cnt_nxt = ADDR_ZERO;
                        crc_nxt = CRC_INIT;
                        state_nxt = ST_LOAD;
                    end
                end
            end
            ST_HALT:
            begin
                if (reconfig_req || auto_reconfig_en_in)
                begin
                    fallback_nxt = 1'b0;
                    cnt_nxt = ADDR_ZERO;
                    state_nxt = ST_SAMPLE;
                end
            end
            default:
                state_nxt = ST_SAMPLE;
        endcase
    end

    // state registers
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            state_r <= ST_SAMPLE;
            cnt_r <= ADDR_ZERO;
            crc_r <= CRC_INIT;
            image_r <= RESET_IMAGE;
            fallback_r <= 1'b0;
            failed_r <= 1'b0;
            cause_r <= CAUSE_NONE;
            ovr_valid_r <= 1'b0;
            ovr_img_r <= 1'b0;
            wdog_r <= 17'h0_0000;
            rd_r <= 1'b0;
            we_r <= 1'b0;
            rd2_r <= 1'b0;
            raddr2_r <= ADDR_ZERO;
            waddr_r <= ADDR_ZERO;
            wdata_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            crc_r <= crc_nxt;
            image_r <= image_nxt;
            fallback_r <= fallback_nxt;
            failed_r <= failed_nxt;
            cause_r <= cause_nxt;
            ovr_valid_r <= ovr_valid_nxt;
            ovr_img_r <= ovr_img_nxt;
            wdog_r <= wdog_nxt;
            rd_r <= rd_nxt;
            we_r <= we_nxt;
            rd2_r <= rd2_nxt;
            raddr2_r <= raddr2_nxt;
            waddr_r <= waddr_nxt;
            wdata_r <= wdata_nxt;
        end
    end

    // flash address: image bit on top, word index below, registered
    logic [FLASH_ADDR_W:0] faddr_r;
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            faddr_r <= '0;
            user_r <= 1'b0;
            halt_r <= 1'b0;
        end
        else
        begin
            faddr_r <= {image_nxt, cnt_r};
            user_r <= (state_nxt == ST_USER);
            halt_r <= (state_nxt == ST_HALT);
        end
    end

    // outputs, all from flip-flops
    assign flash_addr_out = faddr_r;
    assign flash_rd_out = rd_r;
    assign configuration_ram_addr_out = waddr_r;
    assign configuration_ram_data_out = wdata_r;
    assign configuration_ram_we_out = we_r;
    assign user_mode_out = user_r;
    assign active_image_out = image_r;
    assign failed_image_out = failed_r;
    assign error_cause_out = cause_r;
    assign halted_out = halt_r;

    // checks
    property p_fallback_flip;
        @(posedge clk_in) disable iff (!reset_n_in)
        (state_r == ST_CHECK && crc_r != image_crc_in && !fallback_r) |=> (image_r != $past(image_r));
    endproperty
    a_fallback_flip: assert property (p_fallback_flip) else $error("fallback did not flip image");

    property p_second_halt;
        @(posedge clk_in) disable iff (!reset_n_in)
        (state_r == ST_CHECK && crc_r != image_crc_in && fallback_r) |=> (state_r == ST_HALT);
    endproperty
    a_second_halt: assert property (p_second_halt) else $error("second error did not halt");

    property p_auto;
        @(posedge clk_in) disable iff (!reset_n_in)
        (state_r == ST_HALT && auto_reconfig_en_in) |=> (state_r == ST_SAMPLE);
    endproperty
    a_auto: assert property (p_auto) else $error("auto reconfig did not restart");

    property p_halt_wait;
        @(posedge clk_in) disable iff (!reset_n_in)
        (state_r == ST_HALT && !reconfig_req && !auto_reconfig_en_in) |=> (state_r == ST_HALT);
    endproperty
    a_halt_wait: assert property (p_halt_wait) else $error("left halt without request");

    property p_req;
        @(posedge clk_in) disable iff (!reset_n_in)
        (state_r == ST_USER && reconfig_req) |=> (state_r == ST_SAMPLE);
    endproperty
    a_req: assert property (p_req) else $error("reconfig request ignored");

    property p_jumper;
        @(posedge clk_in) disable iff (!reset_n_in)
        (state_r == ST_SAMPLE && cnt_r == SAMPLE_WAIT && !ovr_valid_r) |=> (image_r == !$past(jumper_s));
    endproperty
    a_jumper: assert property (p_jumper) else $error("jumper image wrong");

    property p_override;
        @(posedge clk_in) disable iff (!reset_n_in)
        (state_r == ST_SAMPLE && cnt_r == SAMPLE_WAIT && ovr_valid_r) |=> (image_r == $past(ovr_img_r));
    endproperty
    a_override: assert property (p_override) else $error("override ignored");

    property p_write_follows_read;
        @(posedge clk_in) disable iff (!reset_n_in)
        (rd2_r && state_r == ST_LOAD) |=> we_r;
    endproperty
    a_write_follows_read: assert property (p_write_follows_read) else $error("ram write missing");

    property p_wdog_cause;
        @(posedge clk_in) disable iff (!reset_n_in)
        (state_r == ST_USER && !reconfig_req && wdog_r == 17'h0_0000) |=> (error_cause_out == CAUSE_WDOG);
    endproperty
    a_wdog_cause: assert property (p_wdog_cause) else $error("watchdog cause missing");
endmodule : dual_image_boot_selector

/* File: rtl/boot_sel_pkg.sv */
/*
 * constants and state type for the dual-image boot selector.
 * assumes a single 100 MHz clock domain.
 */
package boot_sel_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int FLASH_ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [FLASH_ADDR_W-1:0] IMAGE_WORDS = 12'h0_100;
    localparam logic [FLASH_ADDR_W-1:0] ADDR_ZERO = 12'h0_000;
    localparam logic [FLASH_ADDR_W-1:0] SAMPLE_WAIT = 12'h0_002;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam int WDOG_TIME_NS = 100000;
    localparam int WDOG_CYCLES = (WDOG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] CAUSE_NONE = 2'h0;
    localparam logic [1:0] CAUSE_CRC = 2'h1;
    localparam logic [1:0] CAUSE_WDOG = 2'h2;
    localparam logic RESET_IMAGE = 1'b0;

    typedef enum logic [2:0]
    {
        ST_SAMPLE = 3'b000,
        ST_LOAD = 3'b001,
        ST_CHECK = 3'b011,
        ST_USER = 3'b010,
        ST_HALT = 3'b110
    } boot_state_e;
endpackage : boot_sel_pkg

/* File: rtl/sync2.sv */
/*
 * two-flop synchroniser for one level.
 * assumes d_in is asynchronous to clk_in.
 */
`timescale 1ns/1ps
module sync2
(
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // data
    input wire logic d_in,
    input wire logic rst_val_in,
    output logic q_out
);
    logic meta_r;

    // two stages, first stage only feeds the second
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            meta_r <= 1'b1;
            q_out <= 1'b1;
        end
        else
        begin
            meta_r <= d_in;
            q_out <= meta_r;
        end
    end
endmodule : sync2

/* File: test/flash_model.sv */
/*
 * configuration flash partner: two images, one-cycle read latency, crc per image.
 * assumes the reader holds address and strobe over each read edge.
 */
`timescale 1ns/1ps
module flash_model
    import boot_sel_pkg::*;
(
    // clock
    input wire logic clk_in,
    // read port
    input wire logic [FLASH_ADDR_W:0] flash_addr_in,
    input wire logic flash_rd_in,
    // fault control, one bit per image
    input wire logic [1:0] bad_crc_in,
    output logic [DATA_W-1:0] flash_data_out,
    output logic [15:0] image_crc_out
);
    logic [15:0] crc_tab [2];

    // word pattern, distinct per image
    function automatic logic [DATA_W-1:0] pat(input logic img, input logic [FLASH_ADDR_W-1:0] a);
        pat = {img ? 16'hC3C3 : 16'h3C3C, 4'h0, a};
    endfunction : pat

    // crc of each image, msb first over whole words
    initial
    begin
        logic [15:0] c;
        logic [DATA_W-1:0] w;
        for (int i = 0; i < 2; i++)
        begin
            c = CRC_INIT;
            for (int k = 0; k < IMAGE_WORDS; k++)
            begin
                w = pat(i[0], k[FLASH_ADDR_W-1:0]);
                for (int b = DATA_W - 1; b >= 0; b--)
                    c = {c[14:0], 1'b0} ^ ((c[15] ^ w[b]) ? CRC_POLY : 16'h0000);
            end
            crc_tab[i] = c;
        end
    end

    // both images held, the addressed one answers a cycle later
    initial flash_data_out = 32'h0000_0000;
    always @(posedge clk_in)
    begin
        if (flash_rd_in)
            flash_data_out <= pat(flash_addr_in[FLASH_ADDR_W], flash_addr_in[FLASH_ADDR_W-1:0]);
        else
            flash_data_out <= ~flash_data_out; // no stale data when idle
    end

    // expected crc of the addressed image, spoiled on request
    assign image_crc_out = crc_tab[flash_addr_in[FLASH_ADDR_W]] ^ {15'h0, bad_crc_in[flash_addr_in[FLASH_ADDR_W]]};
endmodule : flash_model

/* File: test/dual_image_boot_selector_tb.sv */
/*
 * self-checking bench for the boot selector with a flash partner.
 * assumes 100 MHz clock and the package constants.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module dual_image_boot_selector_tb;
    import boot_sel_pkg::*;
    logic clk_in = 0, reset_n_in = 0, jmp = 1, st_n = 1, cfg_n = 1, upg_n = 1, upv = 0, upi = 0, auto_en = 0, kick = 0;
    logic [FLASH_ADDR_W:0] f_addr;
    logic f_rd, we, user, act, fail, halt, exp_img = 0, chk_en = 0;
    logic [DATA_W-1:0] f_data, c_data;
    logic [15:0] crc;
    logic [FLASH_ADDR_W-1:0] c_addr;
    logic [1:0] cause, bad = 2'b00;
    int err_total = 0, checks = 0, wr_cnt = 0, cyc = 0, n;

    // ----------------------------------------
    // clock, units, monitors
    // ----------------------------------------
    initial forever #5 clk_in = ~clk_in;
    dual_image_boot_selector uut (.clk_in(clk_in), .reset_n_in(reset_n_in), .image_jumper_in(jmp),
        .config_status_line_n_in(st_n), .config_request_n_in(cfg_n), .upgrade_reconfig_request_n_in(upg_n),
        .upgrade_image_valid_in(upv), .upgrade_image_in(upi), .auto_reconfig_en_in(auto_en),
        .user_wdog_kick_in(kick), .flash_addr_out(f_addr), .flash_rd_out(f_rd), .flash_data_in(f_data),
        .image_crc_in(crc), .configuration_ram_addr_out(c_addr), .configuration_ram_data_out(c_data), .configuration_ram_we_out(we),
        .user_mode_out(user), .active_image_out(act), .failed_image_out(fail), .error_cause_out(cause),
        .halted_out(halt));
    flash_model fm (.clk_in(clk_in), .flash_addr_in(f_addr), .flash_rd_in(f_rd), .bad_crc_in(bad),
        .flash_data_out(f_data), .image_crc_out(crc));
    // count ram writes and compare their data
    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            err_total++;
            end_of_test();
        end
        if (we === 1'b1)
        begin
            wr_cnt++;
            if (chk_en) `CHK(c_data, {exp_img ? 16'hC3C3 : 16'h3C3C, 4'h0, c_addr})
        end
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic do_reset();
        @(posedge clk_in);
        reset_n_in <= 0;
        repeat (3) @(posedge clk_in);
        reset_n_in <= 1;
        wr_cnt = 0;
    endtask : do_reset
    task automatic wait_end();
        repeat (8) @(posedge clk_in);
        n = 0;
        while (user !== 1'b1 && halt !== 1'b1 && n < 2000)
        begin
            @(posedge clk_in);
            n++;
        end
        #1;
    endtask : wait_end
    task automatic pulse_src(input int s);
        wr_cnt = 0;
        @(posedge clk_in);
        st_n <= (s != 0);
        cfg_n <= (s != 1);
        upg_n <= (s != 2);
        repeat (4) @(posedge clk_in);
        {st_n, cfg_n, upg_n} <= 3'b111;
        wait_end();
    endtask : pulse_src

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_jumper();
        chk_en = 1;
        for (int i = 0; i < 2; i++)
        begin
            exp_img = i[0];
            jmp <= ~i[0];
            do_reset();
            wait_end();
            `CHK(user, 1'b1)
            `CHK(act, i[0])
            `CHK(wr_cnt, 256)
            `CHK(cause, CAUSE_NONE)
        end
        chk_en = 0;
    endtask : t_jumper
    task automatic t_override();
        chk_en = 1;
        exp_img = 1;
        @(posedge clk_in);
        upv <= 1;
        upi <= 1;
        @(posedge clk_in);
        upv <= 0;
        pulse_src(1);
        `CHK(act, 1'b1)
        `CHK(wr_cnt, 256)
        chk_en = 0;
    endtask : t_override
    task automatic t_crc();
        jmp <= 1;
        bad <= 2'b01;
        do_reset();
        wait_end();
        `CHK({user, act, fail, cause}, {3'b110, CAUSE_CRC})
        bad <= 2'b11;
        do_reset();
        wait_end();
        repeat (50) @(posedge clk_in);
        `CHK({halt, user}, 2'b10)
        auto_en <= 1;
        repeat (20) @(posedge clk_in);
        `CHK(halt, 1'b0)
        auto_en <= 0;
        bad <= 2'b00;
        wait_end();
        for (int s = 0; s < 3; s++)
        begin
            pulse_src(s);
            `CHK({user, wr_cnt == 256}, 2'b11)
        end
    endtask : t_crc
    task automatic t_wdog();
        do_reset();
        wait_end();
        kick <= 1;
        repeat (12000) @(posedge clk_in);
        `CHK(user, 1'b1)
        kick <= 0;
        n = 0;
        while (user === 1'b1 && n < 10100)
        begin
            @(posedge clk_in);
            n++;
        end
        `CHK(n >= WDOG_CYCLES - 3 && n <= WDOG_CYCLES + 4, 1'b1)
        wait_end();
        `CHK({user, act, fail, cause}, {3'b110, CAUSE_WDOG})
        repeat (10100) @(posedge clk_in);
        `CHK(halt, 1'b1)
    endtask : t_wdog

    task automatic end_of_test();
        if (err_total == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test

    initial
    begin
        t_jumper();
        t_override();
        t_crc();
        t_wdog();
        end_of_test();
    end
endmodule : dual_image_boot_selector_tb
